// file: hdl/csr_cfg.svh
// Register offsets, field positions, reset values and timing counts of the clock source block.
`ifndef CSR_CFG_SVH
`define CSR_CFG_SVH
// Byte offsets of the registers on the bus.
`define CSR_OFF_CTRL1 8'h00
`define CSR_OFF_CTRL2 8'h04
`define CSR_OFF_TRIM 8'h08
`define CSR_OFF_STATUS 8'h0C
// Field positions in the first control register.
`define CSR_C1_SEL_HI 7
`define CSR_C1_SEL_LO 6
`define CSR_C1_REFDIV_HI 5
`define CSR_C1_REFDIV_LO 3
`define CSR_C1_INTSEL 2
`define CSR_C1_INTOUT_EN 1
`define CSR_C1_INTSTOP_EN 0
// Field positions in the second control register.
`define CSR_C2_BUSDIV_HI 7
`define CSR_C2_BUSDIV_LO 6
`define CSR_C2_LOWPWR 3
`define CSR_C2_OSCREQ 2
`define CSR_C2_EXTOUT_EN 1
`define CSR_C2_EXTSTOP_EN 0
// Field positions in the status and control register.
`define CSR_SC_STATUS_HI 3
`define CSR_SC_STATUS_LO 2
`define CSR_SC_OSCRDY 1
`define CSR_SC_FINETRIM 0
// Reset values: loop engaged internal, bus divide by 2.
`define CSR_RST_CTRL1 8'h04
`define CSR_RST_CTRL2 8'h40
`define CSR_RST_TRIM 8'h80
// Startup times in microseconds, the clock rate in MHz, and the oscillator init and switch counts in cycles.
`define CSR_CLK_MHZ 40
`define CSR_IRST_US 60
`define CSR_ACQ_US 1000
`define CSR_OSC_INIT_CYCLES 4096
`define CSR_SWITCH_CYCLES 4
// Cycle counts derived from the times above.
`define CSR_IRST_CYC (`CSR_IRST_US * `CSR_CLK_MHZ)
`define CSR_ACQ_CYC (`CSR_ACQ_US * `CSR_CLK_MHZ)
`endif

// file: hdl/csr_pkg.sv
// Types shared by the clock source block.
package csr_pkg;
  // Output clock source codes, as reported in the status field.
  typedef enum logic [1:0]
  {
    CSR_SRC_LOOP = 2'b00,
    CSR_SRC_INT = 2'b01,
    CSR_SRC_EXT = 2'b10
  } csr_src_type;

  // Loop lock sequencer states.
  typedef enum logic [1:0]
  {
    CSR_LK_OFF = 2'b00,
    CSR_LK_IRST = 2'b01,
    CSR_LK_ACQ = 2'b10,
    CSR_LK_LOCK = 2'b11
  } csr_lock_type;

  // Control fields decoded from the registers.
  typedef struct packed
  {
    logic [1:0] clock_select_field;
    logic [2:0] reference_divider;
    logic internal_ref_select;
    logic internal_ref_output_enable;
    logic int_ref_stop_enable;
    logic [1:0] bus_divider;
    logic low_power_bit;
    logic ext_oscillator_request;
    logic ext_ref_output_enable;
    logic ext_ref_stop_enable;
  } csr_ctrl_type;

  // Clock gating outputs toward the clock generators.
  typedef struct packed
  {
    logic loop_enable;
    logic loop_ref_external;
    logic int_ref_enable;
    logic ext_ref_enable;
    logic aux_ext_ref_gate;
    logic fixed_freq_gate;
    logic [1:0] out_source;
    logic [1:0] bus_divider;
    logic [2:0] reference_divider;
  } csr_gate_type;
endpackage

// file: hdl/csr_clock_source.sv
// Clock source control: mode decode, lock sequencing, reference gating and AHB-Lite registers.
// Behaviour
// - Enable bit drives external reference to aux output.
// - Internal select keeps external reference off loop.
// - Stop enable keeps external reference alive in stop.
// - Divided loop reference drives fixed frequency clock.
// - Valid flag high always in loop-engaged modes.
// - Bypass modes: valid needs reference divider threshold.
// - Reset into loop-engaged internal, bus divide 2.
// - Loop locks after internal reference startup, acquisition.
// - Oscillator initialised set after init cycles.
// - Status keeps value between loop-engaged modes.
// - Select 00, internal select 0 gives engaged external.
// - Select 10 bypasses; low power needs debug inactive.
// - Initialised flag clears only on enable or request clear.
`timescale 1ns/10ps
`include "csr_cfg.svh"
module csr_clock_source
  import csr_pkg::*;
#(
  parameter int IRST_CYCLES = `CSR_IRST_CYC,
  parameter int ACQ_CYCLES = `CSR_ACQ_CYC,
  parameter int OSC_INIT_CYCLES = `CSR_OSC_INIT_CYCLES
)
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_enable,
  // AHB-Lite slave port.
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Chip state inputs.
  input wire logic stop_mode,
  input wire logic background_debug_active,
  input wire logic ext_ref_present,
  // Clock control outputs.
  output csr_gate_type gate,
  output logic aux_ext_ref_clock,
  output logic fixed_freq_clock,
  output logic fixed_clock_valid,
  output logic main_output_clock
);

  // Architectural register storage.
  logic [7:0] ctrl1_reg, ctrl1_next;
  logic [7:0] ctrl2_reg, ctrl2_next;
  logic [7:0] trim_reg, trim_next;
  logic fine_trim_reg, fine_trim_next;
  logic oscillator_initialised_reg, oscillator_initialised_next;
  // Captured address phase of a pending write.
  logic wr_pend_reg, wr_pend_next;
  logic [7:0] wr_addr_reg, wr_addr_next;
  logic [31:0] hrdata_reg, hrdata_next;
  // Oscillator init counter and lock sequencer.
  logic [12:0] osc_cnt_reg, osc_cnt_next;
  csr_lock_type lock_reg, lock_next;
  logic [31:0] lock_cnt_reg, lock_cnt_next;
  // Output multiplexer and reported source.
  csr_src_type mux_reg, mux_next;
  csr_src_type status_reg, status_next;
  logic [2:0] sw_cnt_reg, sw_cnt_next;

  // Decoded control fields.
  csr_ctrl_type ctl;
  logic bypass_mode;
  logic lp_active;
  logic ext_needed;
  logic int_needed;
  logic loop_on;
  csr_src_type want_src;
  logic [2:0] ff_threshold;
  logic addr_phase;

  // Decodes the control registers into named fields.
  always_comb
  begin
    ctl.clock_select_field = ctrl1_reg[`CSR_C1_SEL_HI:`CSR_C1_SEL_LO];
    ctl.reference_divider = ctrl1_reg[`CSR_C1_REFDIV_HI:`CSR_C1_REFDIV_LO];
    ctl.internal_ref_select = ctrl1_reg[`CSR_C1_INTSEL];
    ctl.internal_ref_output_enable = ctrl1_reg[`CSR_C1_INTOUT_EN];
    ctl.int_ref_stop_enable = ctrl1_reg[`CSR_C1_INTSTOP_EN];
    ctl.bus_divider = ctrl2_reg[`CSR_C2_BUSDIV_HI:`CSR_C2_BUSDIV_LO];
    ctl.low_power_bit = ctrl2_reg[`CSR_C2_LOWPWR];
    ctl.ext_oscillator_request = ctrl2_reg[`CSR_C2_OSCREQ];
    ctl.ext_ref_output_enable = ctrl2_reg[`CSR_C2_EXTOUT_EN];
    ctl.ext_ref_stop_enable = ctrl2_reg[`CSR_C2_EXTSTOP_EN];
  end

  // Mode decode and clock gating.
  always_comb
  begin
    // Select 01 or 10 bypasses the loop; 00 engages it.
    bypass_mode = (ctl.clock_select_field != 2'h0);
    // Low power disables the loop only when debug is inactive.
    lp_active = bypass_mode && ctl.low_power_bit && !background_debug_active;
    loop_on = !lp_active && !stop_mode;
    // External reference runs for the aux output or for an external mode.
    ext_needed = (ctl.ext_ref_output_enable
                  && (!stop_mode || ctl.ext_ref_stop_enable))
                 || (!stop_mode && (ctl.clock_select_field == 2'h2
                     || (!ctl.internal_ref_select && loop_on)));
    int_needed = (!stop_mode && (ctl.internal_ref_select
                  || ctl.clock_select_field == 2'h1))
                 || (ctl.internal_ref_output_enable
                     && (!stop_mode || ctl.int_ref_stop_enable));
    // Requested output source.
    if (ctl.clock_select_field == 2'h1)
    begin
      want_src = CSR_SRC_INT;
    end
    else if (ctl.clock_select_field == 2'h2)
    begin
      want_src = CSR_SRC_EXT;
    end
    else
    begin
      want_src = CSR_SRC_LOOP;
    end
    // Bypass threshold on the reference divider per bus divider.
    ff_threshold = 3'(ctl.bus_divider) + 3'h2;
    gate.loop_enable = loop_on;
    // Internal select 1 keeps the external reference off the loop.
    gate.loop_ref_external = !ctl.internal_ref_select;
    gate.int_ref_enable = int_needed;
    gate.ext_ref_enable = ext_needed;
    gate.aux_ext_ref_gate = ctl.ext_ref_output_enable
                            && (!stop_mode || ctl.ext_ref_stop_enable);
    gate.fixed_freq_gate = loop_on;
    gate.out_source = mux_reg;
    gate.bus_divider = ctl.bus_divider;
    gate.reference_divider = ctl.reference_divider;
  end

  // Register the clock control indications.
  logic aux_next, ffclk_next, ffe_next, mainclk_next;
  always_comb
  begin
    aux_next = gate.aux_ext_ref_gate && ext_ref_present;
    ffclk_next = gate.fixed_freq_gate;
    // Always valid when engaged, threshold-gated when bypassed.
    ffe_next = !bypass_mode || (ctl.reference_divider >= ff_threshold);
    mainclk_next = !stop_mode && (mux_reg != CSR_SRC_LOOP || lock_reg == CSR_LK_LOCK);
  end

  // AHB-Lite decode and register next-state logic.
  always_comb
  begin
    addr_phase = hsel && hready && htrans[1];
    ctrl1_next = ctrl1_reg;
    ctrl2_next = ctrl2_reg;
    trim_next = trim_reg;
    fine_trim_next = fine_trim_reg;
    wr_pend_next = addr_phase && hwrite;
    wr_addr_next = addr_phase ? haddr : wr_addr_reg;
    hrdata_next = hrdata_reg;
    // Writes land in the data phase; trim is never loaded by hardware.
    if (wr_pend_reg)
    begin
      unique case (wr_addr_reg)
        `CSR_OFF_CTRL1: ctrl1_next = hwdata[7:0];
        `CSR_OFF_CTRL2: ctrl2_next = hwdata[7:0];
        `CSR_OFF_TRIM: trim_next = hwdata[7:0];
        `CSR_OFF_STATUS: fine_trim_next = hwdata[`CSR_SC_FINETRIM];
        default: ;
      endcase
    end
    // Reads capture data at the address phase; unmapped reads give zero.
    if (addr_phase && !hwrite)
    begin
      unique case (haddr)
        `CSR_OFF_CTRL1: hrdata_next = {24'h000000, ctrl1_reg};
        `CSR_OFF_CTRL2: hrdata_next = {24'h000000, ctrl2_reg};
        `CSR_OFF_TRIM: hrdata_next = {24'h000000, trim_reg};
        `CSR_OFF_STATUS: hrdata_next = {28'h0000000, status_reg,
                                         oscillator_initialised_reg, fine_trim_reg};
        default: hrdata_next = 32'h00000000;
      endcase
    end
  end

  // Oscillator init flag: set after init cycles, cleared by request clear, or by enable clear when no external mode is selected.
  always_comb
  begin
    osc_cnt_next = osc_cnt_reg;
    oscillator_initialised_next = oscillator_initialised_reg;
    if (!ctl.ext_oscillator_request || !ctl.ext_ref_output_enable
        && ctl.clock_select_field != 2'h2 && (ctl.internal_ref_select
        || ctl.clock_select_field != 2'h0))
    begin
      // Clearing the request, or the output enable outside the external modes, restarts the oscillator from scratch.
      osc_cnt_next = 13'h0000;
      if (!ctl.ext_oscillator_request || !ctl.ext_ref_output_enable)
      begin
        oscillator_initialised_next = 1'b0;
      end
    end
    else if (ext_needed && ext_ref_present && !oscillator_initialised_reg)
    begin
      if (osc_cnt_reg >= 13'(OSC_INIT_CYCLES - 1))
      begin
        oscillator_initialised_next = 1'b1;
      end
      else
      begin
        osc_cnt_next = osc_cnt_reg + 13'h0001;
      end
    end
  end

  // Loop lock sequencer: reference startup, then acquisition.
  always_comb
  begin
    lock_next = lock_reg;
    lock_cnt_next = lock_cnt_reg + 32'h00000001;
    unique case (lock_reg)
      CSR_LK_OFF:
      begin
        lock_cnt_next = 32'h00000000;
        if (loop_on)
        begin
          lock_next = CSR_LK_IRST;
        end
      end
      CSR_LK_IRST:
      begin
        // Lock is attempted only once the internal reference is stable.
        if (lock_cnt_reg >= 32'(IRST_CYCLES - 1))
        begin
          lock_next = CSR_LK_ACQ;
          lock_cnt_next = 32'h00000000;
        end
      end
      CSR_LK_ACQ:
      begin
        if (lock_cnt_reg >= 32'(ACQ_CYCLES - 1))
        begin
          lock_next = CSR_LK_LOCK;
        end
      end
      CSR_LK_LOCK:
      begin
        lock_cnt_next = 32'h00000000;
      end
    endcase
    if (!loop_on)
    begin
      lock_next = CSR_LK_OFF;
    end
  end

  // Output multiplexer switch and status reporting.
  always_comb
  begin
    mux_next = mux_reg;
    status_next = status_reg;
    sw_cnt_next = 3'h0;
    if (want_src != mux_reg)
    begin
      // Switch after a few cycles of the new source; an external source must be present.
      if (want_src == CSR_SRC_EXT && !ext_ref_present)
      begin
        sw_cnt_next = 3'h0;
      end
      else if (sw_cnt_reg >= 3'(`CSR_SWITCH_CYCLES - 1))
      begin
        mux_next = want_src;
      end
      else
      begin
        sw_cnt_next = sw_cnt_reg + 3'h1;
      end
    end
    // Status follows the multiplexer; both engaged modes report one code.
    status_next = mux_reg;
  end

  // Registers all state; the clock enable freezes everything.
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl1_reg <= `CSR_RST_CTRL1;
      ctrl2_reg <= `CSR_RST_CTRL2;
      trim_reg <= `CSR_RST_TRIM;
      fine_trim_reg <= 1'b0;
      oscillator_initialised_reg <= 1'b0;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata_reg <= 32'h00000000;
      osc_cnt_reg <= 13'h0000;
      lock_reg <= CSR_LK_OFF;
      lock_cnt_reg <= 32'h00000000;
      mux_reg <= CSR_SRC_LOOP;
      status_reg <= CSR_SRC_LOOP;
      sw_cnt_reg <= 3'h0;
      aux_ext_ref_clock <= 1'b0;
      fixed_freq_clock <= 1'b0;
      fixed_clock_valid <= 1'b0;
      main_output_clock <= 1'b0;
    end
    else if (clk_enable)
    begin
      ctrl1_reg <= ctrl1_next;
      ctrl2_reg <= ctrl2_next;
      trim_reg <= trim_next;
      fine_trim_reg <= fine_trim_next;
      oscillator_initialised_reg <= oscillator_initialised_next;
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
      hrdata_reg <= hrdata_next;
      osc_cnt_reg <= osc_cnt_next;
      lock_reg <= lock_next;
      lock_cnt_reg <= lock_cnt_next;
      mux_reg <= mux_next;
      status_reg <= status_next;
      sw_cnt_reg <= sw_cnt_next;
      aux_ext_ref_clock <= aux_next;
      fixed_freq_clock <= ffclk_next;
      fixed_clock_valid <= ffe_next;
      main_output_clock <= mainclk_next;
    end
  end

  // The slave always answers in zero wait states with OKAY.
  assign hrdata = hrdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

endmodule

// file: tb/csr_ext_ref_model.sv
// Behavioural external reference source that starts some cycles after it is enabled.
`timescale 1ns/10ps
module csr_ext_ref_model
#(
  parameter int REF_HZ = 32768,
  parameter int START_CYCLES = 6
)
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic ref_enable,
  output logic ref_present
);
  // The source only runs when its frequency lies in the accepted range.
  localparam bit REF_OK = (REF_HZ >= 31250) && (REF_HZ <= 5000000);
  // Startup cycles seen since the source was enabled.
  int start_cnt;
  // A disabled source restarts from zero, like a real oscillator.
  always @(posedge clk_sys or negedge reset_n)
    if (!reset_n)
      start_cnt <= 0;
    else if (!ref_enable)
      start_cnt <= 0;
    else if (start_cnt < START_CYCLES)
      start_cnt <= start_cnt + 1;
  // The clock is present only after startup, and drops at once on disable.
  assign ref_present = REF_OK && ref_enable && (start_cnt == START_CYCLES);
endmodule

// file: tb/csr_clock_source_properties.sv
// Checker of the clock source block's port behaviour.
`timescale 1ns/10ps
module csr_clock_source_properties
  import csr_pkg::*;
#(
  parameter int IRST_CYCLES = 8,
  parameter int ACQ_CYCLES = 16
)
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_enable,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic stop_mode,
  input wire logic background_debug_active,
  input wire logic ext_ref_present,
  input wire csr_gate_type gate,
  input wire logic aux_ext_ref_clock,
  input wire logic fixed_freq_clock,
  input wire logic fixed_clock_valid,
  input wire logic main_output_clock
);
  // Shortest possible time from loop enable to lock, with slack for the registers.
  localparam int LOCK_MIN = IRST_CYCLES + ACQ_CYCLES - 2;
  // Cycles the loop has run since it was last switched off.
  logic [15:0] lock_cnt_reg;
  logic [15:0] lock_cnt_next;
  // True when the dividers meet the bypass threshold.
  logic thr_met;
  assign thr_met = {1'b0, gate.reference_divider} >= ({2'b00, gate.bus_divider} + 4'h2);
  // The counter restarts whenever the loop is off and saturates at its top.
  always_comb
  begin
    lock_cnt_next = lock_cnt_reg;
    if (!gate.loop_enable)
      lock_cnt_next = 16'h0000;
    else if (clk_enable && (lock_cnt_reg != 16'hFFFF))
      lock_cnt_next = lock_cnt_reg + 16'h0001;
  end
  // Registers the loop run counter.
  always_ff @(posedge clk_sys or negedge reset_n)
    if (!reset_n)
      lock_cnt_reg <= 16'h0000;
    else
      lock_cnt_reg <= lock_cnt_next;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  fcv_low_a: assert property (!fixed_clock_valid |-> $past(!thr_met))
    else $error("fixed clock valid low with threshold met");
  fcv_high_a: assert property ($past(thr_met && clk_enable) |-> fixed_clock_valid)
    else $error("fixed clock valid missing");
  aux_follow_a: assert property (reset_n && clk_enable |=>
    aux_ext_ref_clock == $past(gate.aux_ext_ref_gate && ext_ref_present))
    else $error("aux reference output wrong");
  ffclk_follow_a: assert property (reset_n && clk_enable |=>
    fixed_freq_clock == $past(gate.fixed_freq_gate))
    else $error("fixed frequency clock wrong");
  debug_loop_a: assert property (background_debug_active && !stop_mode
    |-> gate.loop_enable)
    else $error("loop off while debug active");
  extref_loop_a: assert property (gate.loop_ref_external && !stop_mode
    |-> gate.ext_ref_enable)
    else $error("loop uses a disabled reference");
  stop_out_a: assert property (reset_n && stop_mode && clk_enable |=> !main_output_clock)
    else $error("output clock runs in stop");
  lock_wait_a: assert property (main_output_clock && gate.out_source == CSR_SRC_LOOP
    |-> lock_cnt_reg >= LOCK_MIN)
    else $error("loop output before lock time");
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus response not ready and okay");
endmodule
bind csr_clock_source csr_clock_source_properties #(.IRST_CYCLES(IRST_CYCLES),
  .ACQ_CYCLES(ACQ_CYCLES)) u_csr_clock_source_properties (.clk_sys(clk_sys),
  .reset_n(reset_n), .clk_enable(clk_enable), .hreadyout(hreadyout), .hresp(hresp),
  .stop_mode(stop_mode), .background_debug_active(background_debug_active),
  .ext_ref_present(ext_ref_present), .gate(gate), .aux_ext_ref_clock(aux_ext_ref_clock),
  .fixed_freq_clock(fixed_freq_clock), .fixed_clock_valid(fixed_clock_valid),
  .main_output_clock(main_output_clock));

// file: tb/tb_top.sv
// Testbench: register sequences over the bus and port checks of the clock source block.
`timescale 1ns/10ps
module tb_top
  import csr_pkg::*;
;
  // Bus and chip state signals driven by the bench.
  logic clk_sys, reset_n, clk_enable, hsel, hwrite, stop_mode, background_debug_active;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  // Outputs of the block and of the reference model.
  logic hreadyout, hresp, ext_ref_present, aux_ext_ref_clock;
  logic fixed_freq_clock, fixed_clock_valid, main_output_clock;
  csr_gate_type gate;
  int errors, checks, cycles;
  // The block under test with short startup counts.
  csr_clock_source #(.IRST_CYCLES(8), .ACQ_CYCLES(16), .OSC_INIT_CYCLES(8))
    u_csr_clock_source (.clk_sys(clk_sys), .reset_n(reset_n), .clk_enable(clk_enable),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .stop_mode(stop_mode), .background_debug_active(background_debug_active),
    .ext_ref_present(ext_ref_present), .gate(gate), .aux_ext_ref_clock(aux_ext_ref_clock),
    .fixed_freq_clock(fixed_freq_clock), .fixed_clock_valid(fixed_clock_valid),
    .main_output_clock(main_output_clock));
  // External reference source.
  csr_ext_ref_model u_csr_ext_ref_model (.clk_sys(clk_sys), .reset_n(reset_n),
    .ref_enable(gate.ext_ref_enable), .ref_present(ext_ref_present));
  // A 40 MHz clock.
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Cuts a hang short.
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      errors++;
      wrap_up();
    end
  end
  // Compares one value and reports a mismatch.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One single word transfer; read data lands in rd.
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_sys);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // Reads a register and compares it.
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    chk(rd, exp);
  endtask
  // Waits some edges and lets their updates settle.
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // Main sequence.
  initial
  begin
    reset_n = 1'b0;
    clk_enable = 1'b1;
    hsel = 1'b1;
    hwrite = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    stop_mode = 1'b0;
    background_debug_active = 1'b0;
    errors = 0;
    checks = 0;
    cycles = 0;
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    tick(4);
    chk(32'(main_output_clock), 32'h0);
    chk(32'(aux_ext_ref_clock), 32'h0);
    chk(32'(fixed_clock_valid), 32'h1);
    rchk(8'h00, 32'h04);
    rchk(8'h04, 32'h40);
    bus(8'h10, 1'b1, 32'hFF);
    rchk(8'h10, 32'h0);
    tick(30);
    chk(32'(main_output_clock), 32'h1);
    chk(32'(fixed_freq_clock), 32'h1);
    bus(8'h08, 1'b1, 32'h5A);
    bus(8'h0C, 1'b1, 32'h1);
    rchk(8'h08, 32'h5A);
    rchk(8'h0C, 32'h1);
    // A write made while the clock enable is low must leave the trim untouched.
    @(posedge clk_sys);
    clk_enable <= 1'b0;
    bus(8'h08, 1'b1, 32'hA5);
    @(posedge clk_sys);
    clk_enable <= 1'b1;
    rchk(8'h08, 32'h5A);
    // Each bus divider with the reference divider just below and at its threshold.
    for (int b = 0; b < 4; b++)
      for (int t = 1; t < 3; t++)
      begin
        bus(8'h04, 1'b1, 32'(b << 6));
        bus(8'h00, 1'b1, 32'h44 | 32'((b + t) << 3));
        tick(2);
        chk(32'(fixed_clock_valid), 32'(t - 1));
        chk(32'(gate.reference_divider), 32'(b + t));
        chk(32'(gate.bus_divider), 32'(b));
      end
    tick(8);
    rchk(8'h0C, 32'h5);
    bus(8'h00, 1'b1, 32'h04);
    bus(8'h04, 1'b1, 32'h40);
    tick(8);
    rchk(8'h0C, 32'h1);
    bus(8'h04, 1'b1, 32'h46);
    rchk(8'h0C, 32'h1);
    tick(30);
    rchk(8'h0C, 32'h3);
    chk(32'(aux_ext_ref_clock), 32'h1);
    bus(8'h00, 1'b1, 32'h18);
    rchk(8'h0C, 32'h3);
    tick(8);
    rchk(8'h0C, 32'h3);
    chk(32'(gate.loop_ref_external), 32'h1);
    chk(32'(gate.int_ref_enable), 32'h0);
    bus(8'h00, 1'b1, 32'h98);
    rchk(8'h0C, 32'h3);
    tick(8);
    rchk(8'h0C, 32'hB);
    chk(32'(gate.out_source), 32'h2);
    bus(8'h04, 1'b1, 32'h4E);
    tick(1);
    chk(32'(gate.loop_enable), 32'h0);
    chk(32'(fixed_freq_clock), 32'h0);
    @(posedge clk_sys);
    background_debug_active <= 1'b1;
    tick(1);
    chk(32'(gate.loop_enable), 32'h1);
    @(posedge clk_sys);
    background_debug_active <= 1'b0;
    rchk(8'h0C, 32'hB);
    bus(8'h00, 1'b1, 32'h44);
    tick(10);
    rchk(8'h0C, 32'h7);
    chk(32'(gate.loop_ref_external), 32'h0);
    chk(32'(gate.int_ref_enable), 32'h1);
    chk(32'(aux_ext_ref_clock), 32'h1);
    @(posedge clk_sys);
    stop_mode <= 1'b1;
    tick(2);
    chk(32'(aux_ext_ref_clock), 32'h0);
    bus(8'h04, 1'b1, 32'h4F);
    tick(10);
    chk(32'(aux_ext_ref_clock), 32'h1);
    @(posedge clk_sys);
    stop_mode <= 1'b0;
    bus(8'h04, 1'b1, 32'h4D);
    rchk(8'h0C, 32'h5);
    wrap_up();
  end
endmodule
